// file: hw/rsf_receive_status.sv
// Receive status flags and interrupt enables of a serial bus receiver.
// Assumes receiver and transfer-controller strobes on sys_clk.
// Operation
// [R1] Ready flag, bit 7, resets to one
// [R2] Clean byte into buffer sets ready
// [R3] Read one then write zero clears ready
// [R4] Transfer controller buffer read clears ready
// [R5] Last transfer byte keeps ready set
// [R6] Processor-moved data: software clears ready
// [R7] Bits 6..3 read zero, writes ignored
// [R8] Master: arbitration, control, length set begun
// [R9] Slave: correct length field sets begun
// [R10] Read one then write zero clears begun
// [R11] Full byte count, no error, sets done
// [R12] Each flag gated by its enable bit
// [R13] Read one then write zero clears done
// [R14] Early end of reception sets aborted
// [R15] Enable bit 7 gates ready interrupt
// [R16] Writing one or unread zero changes nothing
`timescale 1ns/1ps
module rsf_receive_status
  import rsf_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Register bus
  input wire rsf_bus_req_t busReq,
  output rsf_bus_rsp_t busRsp,
  // Receiver events
  input wire rsf_rx_evt_t rxEvt,
  // Block transfer controller
  input wire rsf_xfer_t xfer,
  output logic byteWaitingReq,
  // Interrupt
  output logic irq
);

  typedef struct packed {
    logic [7:0] irqEnable;
    logic [7:0] rxBuffer;
    logic irq;
  } rsf_top_t;

  rsf_top_t state;
  rsf_top_t next_state;
  logic rdAcc;
  logic wrAcc;
  logic [31:0] rdValue;
  logic [3:0] flags;
  logic [3:0] setEv;
  logic [3:0] hwClr;
  logic [3:0] rdSeen;
  logic [3:0] wrZero;
  logic [7:0] statusReg;
  logic stWrite;
  logic stRead;

  // ****************************************************************
  // Bus slave
  // ****************************************************************
  rsf_bus_slave u_slave (
    .sys_clk(sys_clk),
    .rst(rst),
    .busReq(busReq),
    .busRsp(busRsp),
    .rdValue(rdValue),
    .rdAcc(rdAcc),
    .wrAcc(wrAcc)
  );

  assign statusReg = rsf_pack_flags(flags);
  assign stRead = rdAcc && busReq.address == RSF_STATUS_OFS;
  assign stWrite = wrAcc && busReq.address == RSF_STATUS_OFS &&
                   busReq.byteenable[0];

  // Read mux, unmapped words read as zero
  always_comb begin
    unique case (busReq.address)
      RSF_STATUS_OFS: rdValue = {24'h000000, statusReg}; // [R7]
      RSF_IRQ_EN_OFS: rdValue = {24'h000000, state.irqEnable};
      RSF_RX_BUF_OFS: rdValue = {24'h000000, state.rxBuffer};
      default: rdValue = RSF_UNMAPPED_RD;
    endcase
  end

  // ****************************************************************
  // Flag events
  // ****************************************************************
  always_comb begin
    setEv = 4'h0;
    hwClr = 4'h0;
    setEv[RSF_IDX_READY] = rxEvt.byteLoaded; // [R2]
    // Buffer read by the processor leaves the flag to software
    hwClr[RSF_IDX_READY] = xfer.bufRead && !xfer.lastByte; // [R4] [R5] [R6]
    setEv[RSF_IDX_BEGUN] = rxEvt.lengthOk &&
      (rxEvt.masterMode ? (rxEvt.arbWon && rxEvt.ctrlSent) : 1'b1); // [R8] [R9]
    setEv[RSF_IDX_DONE] = rxEvt.countDone && !rxEvt.aborted; // [R11]
    setEv[RSF_IDX_ABORT] = rxEvt.aborted; // [R14]
  end

  // Arming uses the value the read returned, not the live flag
  assign rdSeen = rsf_unpack_flags(busRsp.readdata[7:0]);
  assign wrZero = ~rsf_unpack_flags(busReq.writedata[7:0]); // [R16]

  // ****************************************************************
  // Flag cells
  // ****************************************************************
  for (genvar i = 0; i < RSF_NFLAGS; i++) begin : g_flag
    rsf_flag_cell #(
      .RESET_VAL(RSF_FLAGS_RST[i]) // [R1]
    ) u_cell (
      .sys_clk(sys_clk),
      .rst(rst),
      .setEv(setEv[i]),
      .hwClr(hwClr[i]),
      .rdSeen(rdSeen[i]),
      .rdAcc(stRead),
      .wrAcc(stWrite),
      .wrZero(wrZero[i]), // [R3] [R10] [R13]
      .flag(flags[i])
    );
  end

  // ****************************************************************
  // Enables, buffer and interrupt
  // ****************************************************************
  always_comb begin
    next_state = state;
    if (wrAcc && busReq.address == RSF_IRQ_EN_OFS &&
        busReq.byteenable[0]) begin
      next_state.irqEnable = busReq.writedata[7:0] & RSF_FLAG_MASK; // [R7]
    end
    if (rxEvt.byteLoaded) begin
      next_state.rxBuffer = rxEvt.rxByte; // [R2]
    end
    next_state.irq = |(statusReg & state.irqEnable); // [R12] [R15]
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state <= '{irqEnable: RSF_IRQ_EN_RST, rxBuffer: RSF_RX_BUF_RST,
                 irq: 1'b0};
    end else begin
      state <= next_state;
    end
  end

  assign irq = state.irq;
  assign byteWaitingReq = flags[RSF_IDX_READY];

  // ****************************************************************
  // Assertions
  // ****************************************************************
  AST_READY_RESET: assert property (@(posedge sys_clk)
    rst |=> statusReg == RSF_STATUS_RST) // [R1]
    else $error("status not at reset value after reset");
  AST_LOAD_SETS: assert property (@(posedge sys_clk) disable iff (rst)
    rxEvt.byteLoaded |=> statusReg[RSF_READY_POS] &&
      state.rxBuffer == $past(rxEvt.rxByte)) // [R2]
    else $error("loaded byte did not set ready");
  AST_DTC_CLEAR: assert property (@(posedge sys_clk) disable iff (rst)
    xfer.bufRead && !xfer.lastByte && !rxEvt.byteLoaded |=>
      !statusReg[RSF_READY_POS]) // [R4]
    else $error("transfer read did not clear ready");
  AST_DTC_LAST: assert property (@(posedge sys_clk) disable iff (rst)
    xfer.bufRead && xfer.lastByte && statusReg[RSF_READY_POS] |=>
      statusReg[RSF_READY_POS]) // [R5]
    else $error("last transfer byte cleared ready");
  AST_RSVD_READ: assert property (@(posedge sys_clk) disable iff (rst)
    stRead |-> (busRsp.readdata[7:0] & RSF_RSVD_MASK) == 8'h00) // [R7]
    else $error("reserved status bits read nonzero");
  AST_MASTER_GATE: assert property (@(posedge sys_clk) disable iff (rst)
    rxEvt.lengthOk && rxEvt.masterMode &&
      !(rxEvt.arbWon && rxEvt.ctrlSent) && !statusReg[RSF_BEGUN_POS]
      |=> !statusReg[RSF_BEGUN_POS]) // [R8]
    else $error("begun set without arbitration and control field");
  AST_SLAVE_BEGUN: assert property (@(posedge sys_clk) disable iff (rst)
    rxEvt.lengthOk && !rxEvt.masterMode |=>
      statusReg[RSF_BEGUN_POS]) // [R9]
    else $error("slave length field did not set begun");
  AST_DONE_SET: assert property (@(posedge sys_clk) disable iff (rst)
    rxEvt.countDone && !rxEvt.aborted |=> statusReg[RSF_DONE_POS]) // [R11]
    else $error("byte count reached but done not set");
  AST_ABORT_SET: assert property (@(posedge sys_clk) disable iff (rst)
    rxEvt.aborted |=> statusReg[RSF_ABORT_POS] &&
      !$past(setEv[RSF_IDX_DONE])) // [R14]
    else $error("early end did not set aborted");
  AST_IRQ_GATE: assert property (@(posedge sys_clk) disable iff (rst)
    ##1 irq == $past(|(statusReg & state.irqEnable))) // [R12]
    else $error("interrupt does not follow enabled flags");
  AST_READY_IRQ: assert property (@(posedge sys_clk) disable iff (rst)
    statusReg[RSF_READY_POS] && !state.irqEnable[RSF_READY_POS] &&
      (statusReg[2:0] & state.irqEnable[2:0]) == 3'h0 |=> !irq) // [R15]
    else $error("ready interrupt raised while disabled");

  COV_BYTE_LOAD: cover property (@(posedge sys_clk) disable iff (rst)
    rxEvt.byteLoaded ##1 xfer.bufRead);
  COV_DTC_LAST: cover property (@(posedge sys_clk) disable iff (rst)
    xfer.bufRead && xfer.lastByte && statusReg[RSF_READY_POS]);
  COV_SW_CLEAR: cover property (@(posedge sys_clk) disable iff (rst)
    stRead ##[1:4] stWrite ##1 statusReg == 8'h00);
  COV_IRQ_RISE: cover property (@(posedge sys_clk) disable iff (rst)
    $rose(irq));

endmodule

// file: hw/rsf_pkg.sv
// Package for the receive status flag block: offsets, fields, carriers.
// Assumes one 100 MHz clock and a synchronous active-high reset.
package rsf_pkg;

  // ****************************************************************
  // Register map (byte addresses on the 32-bit bus)
  // ****************************************************************
  localparam logic [3:0] RSF_STATUS_OFS = 4'h0;
  localparam logic [3:0] RSF_IRQ_EN_OFS = 4'h4;
  localparam logic [3:0] RSF_RX_BUF_OFS = 4'h8;

  // ****************************************************************
  // Field positions in the receive status register
  // ****************************************************************
  localparam int RSF_READY_POS = 7;
  localparam int RSF_BEGUN_POS = 2;
  localparam int RSF_DONE_POS = 1;
  localparam int RSF_ABORT_POS = 0;
  localparam logic [7:0] RSF_FLAG_MASK = 8'h87;
  localparam logic [7:0] RSF_RSVD_MASK = 8'h78;

  // ****************************************************************
  // Flag cell indices and reset values
  // ****************************************************************
  localparam int RSF_NFLAGS = 4;
  localparam int RSF_IDX_ABORT = 0;
  localparam int RSF_IDX_DONE = 1;
  localparam int RSF_IDX_BEGUN = 2;
  localparam int RSF_IDX_READY = 3;
  localparam logic [3:0] RSF_FLAGS_RST = 4'h8;
  localparam logic [7:0] RSF_STATUS_RST = 8'h80;
  localparam logic [7:0] RSF_IRQ_EN_RST = 8'h00;
  localparam logic [7:0] RSF_RX_BUF_RST = 8'h00;
  localparam logic [31:0] RSF_UNMAPPED_RD = 32'h00000000;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic read;
    logic write;
    logic [3:0] address;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } rsf_bus_req_t;

  typedef struct packed {
    logic [31:0] readdata;
    logic waitrequest;
  } rsf_bus_rsp_t;

  typedef struct packed {
    logic byteLoaded;
    logic [7:0] rxByte;
    logic masterMode;
    logic arbWon;
    logic ctrlSent;
    logic lengthOk;
    logic countDone;
    logic aborted;
  } rsf_rx_evt_t;

  typedef struct packed {
    logic bufRead;
    logic lastByte;
  } rsf_xfer_t;

  typedef struct packed {
    logic flag;
    logic armed;
  } rsf_cell_t;

  // Four flag cells to the 8-bit register layout and back
  function automatic logic [7:0] rsf_pack_flags(input logic [3:0] f);
    return {f[RSF_IDX_READY], 4'h0, f[RSF_IDX_BEGUN], f[RSF_IDX_DONE],
            f[RSF_IDX_ABORT]};
  endfunction

  function automatic logic [3:0] rsf_unpack_flags(input logic [7:0] r);
    return {r[RSF_READY_POS], r[RSF_BEGUN_POS], r[RSF_DONE_POS],
            r[RSF_ABORT_POS]};
  endfunction

endpackage

// file: hw/rsf_bus_slave.sv
// Avalon-MM slave handshake: one wait state, registered read data.
// Assumes the master holds its request until waitrequest is seen low.
`timescale 1ns/1ps
module rsf_bus_slave
  import rsf_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Bus side
  input wire rsf_bus_req_t busReq,
  output rsf_bus_rsp_t busRsp,
  // Register side
  input wire logic [31:0] rdValue,
  output logic rdAcc,
  output logic wrAcc
);

  rsf_bus_rsp_t state;
  rsf_bus_rsp_t next_state;

  // ****************************************************************
  // Handshake
  // ****************************************************************
  always_comb begin
    next_state = state;
    next_state.waitrequest = 1'b1;
    if ((busReq.read || busReq.write) && state.waitrequest) begin
      next_state.waitrequest = 1'b0;
    end
    if (busReq.read && state.waitrequest) begin
      next_state.readdata = rdValue;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state <= '{readdata: 32'h00000000, waitrequest: 1'b1};
    end else begin
      state <= next_state;
    end
  end

  assign busRsp = state;
  assign rdAcc = busReq.read && !state.waitrequest;
  assign wrAcc = busReq.write && !state.waitrequest;

  AST_ONE_WAIT: assert property (@(posedge sys_clk) disable iff (rst)
    (busReq.read || busReq.write) && state.waitrequest |=>
      !state.waitrequest)
    else $error("request not answered after one wait state");
  AST_WAIT_PULSE: assert property (@(posedge sys_clk) disable iff (rst)
    !state.waitrequest |=> state.waitrequest)
    else $error("waitrequest low for more than one cycle");

endmodule

// file: hw/rsf_flag_cell.sv
// One sticky status flag, cleared by writing 0 after reading it as 1.
// Assumes one-cycle pulses on the same clock; a set beats any clear.
`timescale 1ns/1ps
module rsf_flag_cell
  import rsf_pkg::*;
#(
  parameter logic RESET_VAL = 1'b0
)
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Event side
  input wire logic setEv,
  input wire logic hwClr,
  // Software side
  input wire logic rdSeen,
  input wire logic rdAcc,
  input wire logic wrAcc,
  input wire logic wrZero,
  output logic flag
);

  rsf_cell_t state;
  rsf_cell_t next_state;

  always_comb begin
    next_state = state;
    if (rdAcc) begin
      next_state.armed = rdSeen;
    end
    if (wrAcc) begin
      next_state.armed = 1'b0;
      if (wrZero && state.armed) begin
        next_state.flag = 1'b0;
      end
    end
    if (hwClr) begin
      next_state.flag = 1'b0;
    end
    if (setEv) begin
      next_state.flag = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state <= '{flag: RESET_VAL, armed: 1'b0};
    end else begin
      state <= next_state;
    end
  end

  assign flag = state.flag;

  AST_SET_WINS: assert property (@(posedge sys_clk) disable iff (rst)
    setEv |=> state.flag) // [R16]
    else $error("flag event lost");
  AST_CLEAR_CAUSE: assert property (@(posedge sys_clk) disable iff (rst)
    $fell(state.flag) |-> $past(hwClr) ||
      $past(wrAcc && wrZero && state.armed)) // [R3]
    else $error("flag cleared without read-then-write-0");
  AST_NO_SW_SET: assert property (@(posedge sys_clk) disable iff (rst)
    wrAcc && !setEv && !state.flag |=> !state.flag) // [R16]
    else $error("software write set a flag");
  AST_CLR_SEQ: assert property (@(posedge sys_clk) disable iff (rst)
    state.armed && wrAcc && wrZero && !setEv |=> !state.flag) // [R10]
    else $error("read-1 then write-0 did not clear");

endmodule

// file: tb/rsf_rx_model.sv
// Far-side model: serial receiver and transfer controller strobes.
// Assumes the bench calls one task at a time on sys_clk.
`timescale 1ns/1ps
module rsf_rx_model
  import rsf_pkg::*;
(
  // Clock
  input wire logic sys_clk,
  // Strobes into the block
  output rsf_rx_evt_t rxEvt,
  output rsf_xfer_t xfer
);
  initial begin
    rxEvt = '0;
    xfer = '0;
  end

  // Role levels of the receiver
  task automatic setMode(input logic m, input logic a, input logic c);
    @(posedge sys_clk);
    rxEvt.masterMode <= m;
    rxEvt.arbWon <= a;
    rxEvt.ctrlSent <= c;
  endtask

  // One-cycle strobe, then one settling edge
  task automatic fire(input int kind, input logic [7:0] b);
    @(posedge sys_clk);
    case (kind)
      0: rxEvt.byteLoaded <= 1'b1;
      1: rxEvt.lengthOk <= 1'b1;
      2: rxEvt.countDone <= 1'b1;
      3: rxEvt.aborted <= 1'b1;
      default: xfer.bufRead <= 1'b1;
    endcase
    rxEvt.rxByte <= b;
    xfer.lastByte <= (kind == 5);
    @(posedge sys_clk);
    rxEvt.byteLoaded <= 1'b0;
    rxEvt.lengthOk <= 1'b0;
    rxEvt.countDone <= 1'b0;
    rxEvt.aborted <= 1'b0;
    xfer.bufRead <= 1'b0;
    // Released byte lines do not keep the last value
    rxEvt.rxByte <= ~b;
    xfer.lastByte <= ~xfer.lastByte;
    @(posedge sys_clk);
  endtask
endmodule

// file: tb/test_rsf_receive_status.sv
// Bench for the receive status flags: bus tasks and scenario tasks.
// Assumes the far-side model drives all receiver and transfer strobes.
`timescale 1ns/1ps
module test_rsf_receive_status
  import rsf_pkg::*;
;
  logic sys_clk;
  logic rst;
  rsf_bus_req_t busReq;
  rsf_bus_rsp_t busRsp;
  rsf_rx_evt_t rxEvt;
  rsf_xfer_t xfer;
  logic byteWaitingReq;
  logic irq;
  logic [31:0] rd;
  int mismatches;
  int compares;

  rsf_receive_status i_rsf_receive_status (.sys_clk(sys_clk), .rst(rst),
    .busReq(busReq), .busRsp(busRsp), .rxEvt(rxEvt), .xfer(xfer),
    .byteWaitingReq(byteWaitingReq), .irq(irq));
  rsf_rx_model i_rsf_rx_model (.sys_clk(sys_clk), .rxEvt(rxEvt),
    .xfer(xfer));

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [7:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    busReq.read <= ~wr;
    busReq.write <= wr;
    busReq.address <= a;
    busReq.writedata <= {24'h000000, d};
    busReq.byteenable <= 4'hF;
    do begin
      @(posedge sys_clk);
      n++;
    end while (busRsp.waitrequest !== 1'b0 && n < 20);
    if (n >= 20) begin
      mismatches++;
      $display("unexpected at %0t: no bus answer", $time);
    end
    rd = busRsp.readdata;
    busReq.read <= 1'b0;
    busReq.write <= 1'b0;
  endtask

  task automatic rdChk(input logic [3:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(rd, {24'h000000, e});
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic conclude();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset();
    rdChk(RSF_STATUS_OFS, 8'h80);
    rdChk(RSF_IRQ_EN_OFS, 8'h00);
    rdChk(4'hC, 8'h00);
    chk({31'h0, byteWaitingReq}, 32'h1);
    chk({31'h0, irq}, 32'h0);
    $display("test reset done");
  endtask

  task automatic t_swclear();
    bus(1'b1, RSF_STATUS_OFS, 8'hFF);
    bus(1'b1, RSF_STATUS_OFS, 8'h00);
    rdChk(RSF_STATUS_OFS, 8'h80);
    bus(1'b1, RSF_STATUS_OFS, 8'hFF);
    rdChk(RSF_STATUS_OFS, 8'h80);
    bus(1'b1, RSF_STATUS_OFS, 8'h00);
    rdChk(RSF_STATUS_OFS, 8'h00);
    chk({31'h0, byteWaitingReq}, 32'h0);
    bus(1'b1, RSF_STATUS_OFS, 8'hFF);
    rdChk(RSF_STATUS_OFS, 8'h00);
    $display("test software clear done");
  endtask

  task automatic t_events();
    i_rsf_rx_model.setMode(1'b0, 1'b0, 1'b0);
    i_rsf_rx_model.fire(1, 8'h00);
    rdChk(RSF_STATUS_OFS, 8'h04);
    i_rsf_rx_model.fire(2, 8'h00);
    i_rsf_rx_model.fire(3, 8'h00);
    i_rsf_rx_model.fire(0, 8'hA5);
    rdChk(RSF_STATUS_OFS, 8'h87);
    rdChk(RSF_RX_BUF_OFS, 8'hA5);
    bus(1'b1, RSF_STATUS_OFS, 8'h80);
    rdChk(RSF_STATUS_OFS, 8'h80);
    bus(1'b1, RSF_STATUS_OFS, 8'h00);
    rdChk(RSF_STATUS_OFS, 8'h00);
    $display("test events done");
  endtask

  task automatic t_master();
    i_rsf_rx_model.setMode(1'b1, 1'b1, 1'b0);
    i_rsf_rx_model.fire(1, 8'h00);
    rdChk(RSF_STATUS_OFS, 8'h00);
    i_rsf_rx_model.setMode(1'b1, 1'b1, 1'b1);
    i_rsf_rx_model.fire(1, 8'h00);
    rdChk(RSF_STATUS_OFS, 8'h04);
    i_rsf_rx_model.fire(0, 8'h3C);
    bus(1'b1, RSF_STATUS_OFS, 8'h00);
    rdChk(RSF_STATUS_OFS, 8'h80);
    $display("test master done");
  endtask

  task automatic t_xfer();
    i_rsf_rx_model.fire(4, 8'h00);
    chk({31'h0, byteWaitingReq}, 32'h0);
    i_rsf_rx_model.fire(0, 8'h5A);
    i_rsf_rx_model.fire(5, 8'h00);
    chk({31'h0, byteWaitingReq}, 32'h1);
    rdChk(RSF_STATUS_OFS, 8'h80);
    $display("test transfer done");
  endtask

  task automatic t_irq();
    bus(1'b1, RSF_IRQ_EN_OFS, 8'hFF);
    rdChk(RSF_IRQ_EN_OFS, 8'h87);
    chk({31'h0, irq}, 32'h1);
    bus(1'b1, RSF_IRQ_EN_OFS, 8'h7F);
    tick(2);
    chk({31'h0, irq}, 32'h0);
    i_rsf_rx_model.fire(1, 8'h00);
    tick(1);
    chk({31'h0, irq}, 32'h1);
    bus(1'b1, RSF_IRQ_EN_OFS, 8'h00);
    tick(2);
    chk({31'h0, irq}, 32'h0);
    bus(1'b1, RSF_IRQ_EN_OFS, 8'h04);
    rdChk(RSF_STATUS_OFS, 8'h84);
    bus(1'b1, RSF_STATUS_OFS, 8'h80);
    tick(2);
    chk({31'h0, irq}, 32'h0);
    $display("test interrupt done");
  endtask

  // ****************************************************************
  // Clock, reset, sequence and watchdog
  // ****************************************************************
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  initial begin
    rst = 1'b1;
    busReq = '0;
    mismatches = 0;
    compares = 0;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    t_reset();
    t_swclear();
    t_events();
    t_master();
    t_xfer();
    t_irq();
    conclude();
  end

  initial begin
    repeat (5000) @(posedge sys_clk);
    mismatches++;
    conclude();
  end
endmodule
